/* src/timer_pkg.sv */
// Constants and types shared by the 8-bit timer/counter core
package timer_pkg;
  // ==========================================================
  // Register byte offsets on the Avalon-MM slave
  localparam logic [4:0] OFS_CTRL_A  = 5'h00; // control_reg_a
  localparam logic [4:0] OFS_CTRL_B  = 5'h04; // control_reg_b
  localparam logic [4:0] OFS_COUNTER = 5'h08; // counter_value
  localparam logic [4:0] OFS_CMP_A   = 5'h0c; // compare_value_a
  localparam logic [4:0] OFS_CMP_B   = 5'h10; // compare_value_b
  localparam logic [4:0] OFS_FLAGS   = 5'h14; // timer_flag_reg
  localparam logic [4:0] OFS_MASK    = 5'h18; // timer_mask_reg
  // ==========================================================
  // Field positions
  localparam int OM_A_LSB   = 6; // Output mode of channel A, bits 7:6 of control A
  localparam int OM_B_LSB   = 4; // Output mode of channel B, bits 5:4 of control A
  localparam int WM_HI_BIT  = 3; // Wave mode bit 2 sits in control B
  localparam int OVF_BIT    = 0; // Flag and mask bit positions
  localparam int MATCH_A_BIT = 1;
  localparam int MATCH_B_BIT = 2;
  // ==========================================================
  // Values after reset and count limits
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] BOTTOM_VAL = 8'h00;
  localparam logic [7:0] MAX_VAL    = 8'hff;
  // ==========================================================
  // Clock select codes
  localparam logic [2:0] CS_STOP   = 3'h0;
  localparam logic [2:0] CS_DIV1   = 3'h1;
  localparam logic [2:0] CS_DIV8   = 3'h2;
  localparam logic [2:0] CS_DIV64  = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1K  = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  // Prescaler taps: divide by 2 to the power of the tap width
  localparam int PRE_W    = 10;
  localparam int TAP_8    = 3;
  localparam int TAP_64   = 6;
  localparam int TAP_256  = 8;
  localparam int TAP_1K   = 10;
  // ==========================================================
  // Wave modes (codes 4 and 6 are reserved and run as normal)
  localparam logic [2:0] WM_NORMAL    = 3'h0;
  localparam logic [2:0] WM_PHASE_MAX = 3'h1;
  localparam logic [2:0] WM_CTC       = 3'h2;
  localparam logic [2:0] WM_FAST_MAX  = 3'h3;
  localparam logic [2:0] WM_PHASE_CMP = 3'h5;
  localparam logic [2:0] WM_FAST_CMP  = 3'h7;
  // Compare output modes
  localparam logic [1:0] OM_OFF    = 2'h0;
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  localparam logic [1:0] OM_CLEAR  = 2'h2;
  localparam logic [1:0] OM_SET    = 2'h3;
  // ==========================================================
  // Per-channel waveform configuration
  typedef struct packed {
    logic [1:0] out_mode; // Output action on match
    logic       fast;     // Fast PWM sequence
    logic       phase;    // Phase correct sequence
  } wave_cfg_type;
  // Bus slave states
  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b01,
    BUS_ANSWER = 2'b10
  } bus_state_type;
endpackage : timer_pkg

/* src/clock_select_unit.sv */
// Clock select stage: prescaler taps and external count pin to a timer tick
`timescale 1ns/1ps
module clock_select_unit
  import timer_pkg::*;
(
  input  wire logic       clock_in,    // System clock
  input  wire logic       rst_in,      // Asynchronous reset, active high
  input  wire logic [2:0] select_in,   // clock_select_field
  input  wire logic       enable_in,   // Low while the timer is powered down
  input  wire logic       ext_pin_in,  // ext_count_pin, asynchronous
  output logic            tick_out     // timer_tick, one-cycle pulse
);
  logic [PRE_W-1:0] pre_r;        // Free-running prescaler
  logic [2:0]       pin_r;        // Three-stage pin synchroniser
  logic             level_r;      // Settled pin level
  logic             ext_rise;     // Settled rising edge
  logic             ext_fall;     // Settled falling edge
  logic             tick_nxt;     // Selected tick
  // ==========================================================
  // Prescaler
  // Runs freely, so a tap may fire early after a select change.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + 1'b1;
    end
  end
  // ==========================================================
  // Pin synchroniser; a change counts once stages two and three agree
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pin_r   <= 3'h0;
      level_r <= 1'b0;
    end else begin
      pin_r <= {pin_r[1:0], ext_pin_in};
      if (pin_r[1] == pin_r[2]) begin
        level_r <= pin_r[2];
      end
    end
  end
  assign ext_rise = (pin_r[1] == pin_r[2]) && pin_r[2] && !level_r;
  assign ext_fall = (pin_r[1] == pin_r[2]) && !pin_r[2] && level_r;
  // ==========================================================
  // Source select
  always_comb begin
    unique case (select_in)
      CS_STOP:     tick_nxt = 1'b0;
      CS_DIV1:     tick_nxt = 1'b1;
      CS_DIV8:     tick_nxt = &pre_r[TAP_8-1:0];
      CS_DIV64:    tick_nxt = &pre_r[TAP_64-1:0];
      CS_DIV256:   tick_nxt = &pre_r[TAP_256-1:0];
      CS_DIV1K:    tick_nxt = &pre_r[TAP_1K-1:0];
      CS_EXT_FALL: tick_nxt = ext_fall;
      CS_EXT_RISE: tick_nxt = ext_rise;
    endcase
  end
  // Power-down gating keeps the counter frozen
  assign tick_out = tick_nxt && enable_in;
endmodule : clock_select_unit

/* src/compare_channel.sv */
// One output compare channel: double buffer, match and waveform output
`timescale 1ns/1ps
module compare_channel
  import timer_pkg::*;
(
  input  wire logic         clock_in,    // System clock
  input  wire logic         rst_in,      // Asynchronous reset, active high
  input  wire logic         tick_in,     // Timer tick
  input  wire wave_cfg_type cfg_in,      // Output configuration
  input  wire logic         write_in,    // Bus write to the compare register
  input  wire logic [7:0]   data_in,     // Bus write data
  input  wire logic [7:0]   counter_in,  // Current counter value
  input  wire logic         down_in,     // Counter counting down
  input  wire logic         update_in,   // Load buffer into active value
  input  wire logic         wrap_in,     // Fast PWM restart at bottom
  output logic [7:0]        buffer_out,  // Register as software sees it
  output logic [7:0]        active_out,  // Value used by the comparator
  output logic              match_out,   // Equal in this cycle
  output logic              wave_out     // Waveform output
);
  // ==========================================================
  // Buffer and active value
  // PWM modes load only at the sequence update point to avoid glitches.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      buffer_out <= RESET_BYTE;
      active_out <= RESET_BYTE;
    end else begin
      if (write_in) begin
        buffer_out <= data_in;
      end
      if (!(cfg_in.fast || cfg_in.phase)) begin
        active_out <= write_in ? data_in : buffer_out;
      end else if (update_in) begin
        active_out <= buffer_out;
      end
    end
  end
  // Comparator runs every cycle
  assign match_out = (counter_in == active_out);
  // ==========================================================
  // Waveform generator
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      wave_out <= 1'b0;
    end else if (tick_in && cfg_in.out_mode != OM_OFF) begin
      if (cfg_in.fast) begin
        // Restart wins so a compare at top keeps the output steady
        if (wrap_in) begin
          wave_out <= (cfg_in.out_mode == OM_CLEAR);
        end else if (match_out) begin
          wave_out <= (cfg_in.out_mode == OM_SET);
        end
      end else if (cfg_in.phase) begin
        if (match_out) begin
          wave_out <= down_in ^ (cfg_in.out_mode == OM_SET);
        end
      end else if (match_out) begin
        unique case (cfg_in.out_mode)
          OM_TOGGLE: wave_out <= !wave_out;
          OM_CLEAR:  wave_out <= 1'b0;
          default:   wave_out <= 1'b1;
        endcase
      end
    end
  end
endmodule : compare_channel

/* src/timer_core.sv */
// 8-bit timer/counter core with Avalon-MM register slave
//
// Notes on behaviour
// - Counter at 0x00 marks bottom.
// - Counter at 0xFF marks maximum.
// - Top asserted when counter equals sequence top.
// - Top is 0xFF or compare A per mode.
// - Counter and both compares are 8-bit registers.
// - Every request shows in the flag register.
// - Each request gated by its mask bit.
// - Tick from prescaler or external count pin.
// - Three-bit clock select in control B.
// - No source selected keeps counter frozen.
// - Clock select output is the timer tick.
// - Both compares checked against counter every cycle.
// - Matches drive waveform outputs A and B.
// - Match sets its compare flag.
// - Counter counts up or down.
// - Bus counter write beats clear or count.
// - Three wave mode bits pick the sequence.
// - Overflow flag set where the mode says.
`timescale 1ns/1ps
module timer_core
  import timer_pkg::*;
(
  input  wire logic        clock_in,                // 40 MHz system clock
  input  wire logic        rst_in,                  // Asynchronous reset, active high
  input  wire logic [4:0]  address_in,              // Avalon byte address
  input  wire logic        read_in,                 // Avalon read
  input  wire logic        write_in,                // Avalon write
  input  wire logic [31:0] writedata_in,            // Avalon write data
  output logic [31:0]      readdata_out,            // Avalon read data
  output logic             waitrequest_out,         // Avalon waitrequest
  input  wire logic        power_reduce_timer_bit_in, // High stops the timer
  input  wire logic        ext_count_pin_in,        // External count pin
  output logic             wave_out_a_out,          // Compare output A
  output logic             wave_out_b_out,          // Compare output B
  output logic [2:0]       irq_req_out,             // Masked requests
  output logic             top_out,                 // Counter at top
  output logic             bottom_out,              // Counter at bottom
  output logic             max_out                  // Counter at maximum
);
  // ==========================================================
  // Declarations
  bus_state_type bus_state_r;     // Slave handshake state
  logic [7:0]    control_reg_a_r; // Output modes and low wave mode bits
  logic [7:0]    control_reg_b_r; // Wave mode high bit and clock select
  logic [7:0]    counter_value_r; // The counter
  logic          down_r;          // Counting direction, high counts down
  logic [2:0]    timer_flag_reg_r; // Sticky request flags
  logic [2:0]    timer_mask_reg_r; // Request enables
  logic [2:0]    flag_set;        // Events this cycle
  logic          accept;          // Request completes at this edge
  logic          wr_ok;           // Write takes effect
  logic [31:0]   read_nxt;        // Read data selected
  logic [2:0]    wave_mode_field; // Sequence select
  logic [2:0]    clock_select_field; // Tick source select
  logic          timer_tick;      // Counter advance enable
  logic          is_fast;         // Fast PWM sequence
  logic          is_phase;        // Phase correct sequence
  logic          top_from_cmp;    // Top comes from compare A
  logic [7:0]    top_val;         // Current top
  logic          at_top;          // Counter equals top
  logic          cnt_wr;          // Bus writes the counter
  logic [7:0]    counter_nxt;     // Next counter value
  logic          down_nxt;        // Next direction
  logic          ovf_evt;         // Overflow event
  logic          update;          // Compare buffer update point
  logic [1:0]    cmp_wr;          // Bus writes a compare register
  logic [7:0]    cmp_buf [2];     // Compare values as written
  logic [7:0]    cmp_act [2];     // Compare values in use
  logic [1:0]    cmp_match;       // Comparator outputs
  logic [1:0]    cmp_wave;        // Waveform outputs
  wave_cfg_type  cfg [2];         // Per-channel configuration

  // ==========================================================
  // Avalon-MM slave
  // One wait state: a request is answered at its second edge.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      bus_state_r <= BUS_IDLE;
    end else begin
      unique case (bus_state_r)
        BUS_IDLE: begin
          if (read_in || write_in) begin
            bus_state_r <= BUS_ANSWER;
          end
        end
        BUS_ANSWER: begin
          bus_state_r <= BUS_IDLE;
        end
      endcase
    end
  end
  assign waitrequest_out = (read_in || write_in) && (bus_state_r == BUS_IDLE);
  assign accept          = (read_in || write_in) && (bus_state_r == BUS_ANSWER);
  assign wr_ok           = accept && write_in;

  // Read mux; unmapped addresses read zero
  always_comb begin
    read_nxt = 32'h0000_0000;
    unique case (address_in)
      OFS_CTRL_A:  read_nxt[7:0] = control_reg_a_r;
      OFS_CTRL_B:  read_nxt[7:0] = control_reg_b_r;
      OFS_COUNTER: read_nxt[7:0] = counter_value_r;
      OFS_CMP_A:   read_nxt[7:0] = cmp_buf[0];
      OFS_CMP_B:   read_nxt[7:0] = cmp_buf[1];
      OFS_FLAGS:   read_nxt[2:0] = timer_flag_reg_r;
      OFS_MASK:    read_nxt[2:0] = timer_mask_reg_r;
      default:     read_nxt = 32'h0000_0000;
    endcase
  end

  // Read data sampled in the wait cycle, stands through the answer
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      readdata_out <= 32'h0000_0000;
    end else if (read_in && bus_state_r == BUS_IDLE) begin
      readdata_out <= read_nxt;
    end
  end

  // ==========================================================
  // Control and mask registers
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      control_reg_a_r  <= RESET_BYTE;
      control_reg_b_r  <= RESET_BYTE;
      timer_mask_reg_r <= 3'h0;
    end else if (wr_ok) begin
      if (address_in == OFS_CTRL_A) begin
        control_reg_a_r <= writedata_in[7:0];
      end
      if (address_in == OFS_CTRL_B) begin
        control_reg_b_r <= writedata_in[7:0];
      end
      if (address_in == OFS_MASK) begin
        timer_mask_reg_r <= writedata_in[2:0];
      end
    end
  end

  // ==========================================================
  // Mode decode
  assign wave_mode_field    = {control_reg_b_r[WM_HI_BIT], control_reg_a_r[1:0]};
  assign clock_select_field = control_reg_b_r[2:0];
  assign is_fast      = (wave_mode_field == WM_FAST_MAX) || (wave_mode_field == WM_FAST_CMP);
  assign is_phase     = (wave_mode_field == WM_PHASE_MAX) || (wave_mode_field == WM_PHASE_CMP);
  // CTC uses compare A directly; the PWM modes use its buffered value
  assign top_from_cmp = (wave_mode_field == WM_CTC) || (wave_mode_field == WM_PHASE_CMP)
                        || (wave_mode_field == WM_FAST_CMP);
  assign top_val      = top_from_cmp ? cmp_act[0] : MAX_VAL;
  assign at_top       = (counter_value_r == top_val);
  assign top_out      = at_top;
  assign bottom_out   = (counter_value_r == BOTTOM_VAL);
  assign max_out      = (counter_value_r == MAX_VAL);

  // ==========================================================
  // Clock select stage
  clock_select_unit u_clock_select (
    .clock_in   (clock_in),
    .rst_in     (rst_in),
    .select_in  (clock_select_field),
    .enable_in  (!power_reduce_timer_bit_in),
    .ext_pin_in (ext_count_pin_in),
    .tick_out   (timer_tick)
  );

  // ==========================================================
  // Counter sequence
  assign cnt_wr = wr_ok && (address_in == OFS_COUNTER);
  always_comb begin
    counter_nxt = counter_value_r;
    down_nxt    = down_r;
    ovf_evt     = 1'b0;
    update      = 1'b0;
    if (cnt_wr) begin
      counter_nxt = writedata_in[7:0];
    end else if (timer_tick) begin
      if (is_phase) begin
        // Turn round at top and at bottom
        if (!down_r && at_top) begin
          down_nxt    = 1'b1;
          counter_nxt = counter_value_r - 8'h01;
          update      = 1'b1;
        end else if (down_r && bottom_out) begin
          down_nxt    = 1'b0;
          counter_nxt = counter_value_r + 8'h01;
          ovf_evt     = 1'b1;
        end else begin
          counter_nxt = down_r ? counter_value_r - 8'h01 : counter_value_r + 8'h01;
        end
      end else begin
        down_nxt = 1'b0;
        if (at_top && (is_fast || wave_mode_field == WM_CTC)) begin
          counter_nxt = BOTTOM_VAL;
          update      = is_fast;
        end else begin
          counter_nxt = counter_value_r + 8'h01;
        end
        // Fast PWM overflows at top, the others at maximum
        ovf_evt = is_fast ? at_top : max_out;
      end
    end
  end

  // Counter register
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      counter_value_r <= RESET_BYTE;
      down_r          <= 1'b0;
    end else begin
      counter_value_r <= counter_nxt;
      down_r          <= down_nxt;
    end
  end

  // ==========================================================
  // Compare channels
  assign cmp_wr[0] = wr_ok && (address_in == OFS_CMP_A);
  assign cmp_wr[1] = wr_ok && (address_in == OFS_CMP_B);
  assign cfg[0]    = '{out_mode: control_reg_a_r[OM_A_LSB +: 2], fast: is_fast, phase: is_phase};
  assign cfg[1]    = '{out_mode: control_reg_a_r[OM_B_LSB +: 2], fast: is_fast, phase: is_phase};

  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_cmp
      compare_channel u_channel (
        .clock_in   (clock_in),
        .rst_in     (rst_in),
        .tick_in    (timer_tick && !cnt_wr),
        .cfg_in     (cfg[ch]),
        .write_in   (cmp_wr[ch]),
        .data_in    (writedata_in[7:0]),
        .counter_in (counter_value_r),
        .down_in    (down_r),
        .update_in  (update),
        .wrap_in    (is_fast && at_top),
        .buffer_out (cmp_buf[ch]),
        .active_out (cmp_act[ch]),
        .match_out  (cmp_match[ch]),
        .wave_out   (cmp_wave[ch])
      );
    end
  endgenerate
  assign wave_out_a_out = cmp_wave[0];
  assign wave_out_b_out = cmp_wave[1];

  // ==========================================================
  // Flags and requests
  // Matches count on the tick so one compare value sets a flag once.
  assign flag_set[OVF_BIT]     = ovf_evt;
  assign flag_set[MATCH_A_BIT] = timer_tick && !cnt_wr && cmp_match[0];
  assign flag_set[MATCH_B_BIT] = timer_tick && !cnt_wr && cmp_match[1];

  // Write one to clear; a new event in the same cycle wins
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      timer_flag_reg_r <= 3'h0;
    end else if (wr_ok && address_in == OFS_FLAGS) begin
      timer_flag_reg_r <= (timer_flag_reg_r & ~writedata_in[2:0]) | flag_set;
    end else begin
      timer_flag_reg_r <= timer_flag_reg_r | flag_set;
    end
  end
  assign irq_req_out = timer_flag_reg_r & timer_mask_reg_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  chk_stop_frozen: assert property (
    (clock_select_field == CS_STOP) && !cnt_wr |=> $stable(counter_value_r)
  ) else $error("counter moved with no clock source");

  // A flag clear is the one legal way for the overflow bit to move without a tick
  chk_no_tick_hold: assert property (
    !timer_tick && !cnt_wr && !(wr_ok && address_in == OFS_FLAGS)
    |=> $stable(counter_value_r) && $stable(timer_flag_reg_r[OVF_BIT])
  ) else $error("counter changed between ticks");

  chk_normal_step: assert property (
    timer_tick && !cnt_wr && wave_mode_field == WM_NORMAL
    |=> counter_value_r == $past(counter_value_r) + 8'h01
  ) else $error("normal mode did not step by one");

  chk_write_wins: assert property (
    cnt_wr |=> counter_value_r == $past(writedata_in[7:0])
  ) else $error("counter write did not take priority");

  chk_ovf_at_max: assert property (
    timer_tick && !cnt_wr && wave_mode_field == WM_NORMAL && max_out
    |=> timer_flag_reg_r[OVF_BIT] && bottom_out
  ) else $error("overflow at maximum missed");

  chk_fast_top_wrap: assert property (
    timer_tick && !cnt_wr && wave_mode_field == WM_FAST_CMP && counter_value_r == cmp_act[0]
    |=> bottom_out && timer_flag_reg_r[OVF_BIT]
  ) else $error("fast mode did not restart at compare A");

  chk_match_flag: assert property (
    timer_tick && !cnt_wr && counter_value_r == cmp_act[1] |=> timer_flag_reg_r[MATCH_B_BIT]
  ) else $error("compare B match flag missed");

  // Only a write of one to this bit may drop it; checked again every cycle it stands
  chk_flag_sticky: assert property (
    timer_flag_reg_r[MATCH_A_BIT]
    && !(wr_ok && address_in == OFS_FLAGS && writedata_in[MATCH_A_BIT])
    |=> timer_flag_reg_r[MATCH_A_BIT]
  ) else $error("flag dropped without a clear");

  chk_irq_masked: assert property (
    timer_flag_reg_r[OVF_BIT] && !timer_mask_reg_r[OVF_BIT] |-> !irq_req_out[OVF_BIT]
  ) else $error("unmasked overflow request");

  chk_bus_answer: assert property (
    (read_in || write_in) && waitrequest_out |=> !waitrequest_out
  ) else $error("slave did not answer after one wait state");

  cov_overflow: cover property (timer_flag_reg_r[OVF_BIT] && irq_req_out[OVF_BIT]);
  cov_match_a:  cover property (flag_set[MATCH_A_BIT]);
  cov_turn:     cover property (is_phase && !down_r ##1 down_r);
  cov_wr_tick:  cover property (cnt_wr && timer_tick);
endmodule : timer_core

/* tb/host_model.sv */
// Host model: Avalon-MM master and external count pin driver
`timescale 1ns/1ps
module host_model
(
  input  wire logic        clock_in,       // System clock
  input  wire logic [31:0] readdata_in,    // Read data from the core
  input  wire logic        waitrequest_in, // Core stall
  output logic [4:0]       address_out,    // Byte address
  output logic             read_out,       // Read strobe
  output logic             write_out,      // Write strobe
  output logic [31:0]      writedata_out,  // Write data
  output logic             pin_out,        // External count pin
  output logic             power_out       // Power reduction bit
);
  // ==========================================================
  // Idle values; the timer is kept powered up
  initial begin
    address_out   = 5'h1f;
    read_out      = 1'b0;
    write_out     = 1'b0;
    writedata_out = 32'h0;
    pin_out       = 1'b0;
    power_out     = 1'b0;
  end
  // One bus cycle, held until waitrequest is sampled low
  task automatic access(input logic wr, input logic [4:0] adr, input logic [7:0] dat,
                        output logic [7:0] rd);
    @(posedge clock_in);
    address_out   <= adr;
    write_out     <= wr;
    read_out      <= !wr;
    writedata_out <= {24'h0, dat};
    do @(posedge clock_in); while (waitrequest_in !== 1'b0);
    rd = readdata_in[7:0];
    read_out      <= 1'b0;
    write_out     <= 1'b0;
    // Released lines do not keep their last value
    address_out   <= ~adr;
    writedata_out <= ~{24'h0, dat};
  endtask : access
  // Pulses on the pin, a rise then a fall each, each level held well past the synchroniser
  task automatic pulses(input int n);
    repeat (n) begin
      repeat (8) @(posedge clock_in);
      pin_out <= 1'b1;
      repeat (8) @(posedge clock_in);
      pin_out <= 1'b0;
    end
    repeat (8) @(posedge clock_in);
  endtask : pulses
endmodule : host_model

/* tb/timer_core_test.sv */
// Self-checking testbench of the timer/counter core
`timescale 1ns/1ps
module timer_core_test
  import timer_pkg::*;
;
  logic clock_in = 1'b0;  // 40 MHz clock
  logic rst_in   = 1'b1;  // Reset, held 4 cycles
  logic [4:0] adr; logic rdn, wrn, pin, pwr, wa, wb, top, bot, mx, wt;
  logic [31:0] wdat, rdat;
  logic [2:0] irq;
  int n_errors = 0, n_checks = 0, cycles = 0;
  always #12.5 clock_in = ~clock_in;
  host_model host_model_inst (.clock_in(clock_in), .readdata_in(rdat), .waitrequest_in(wt),
    .address_out(adr), .read_out(rdn), .write_out(wrn), .writedata_out(wdat),
    .pin_out(pin), .power_out(pwr));
  timer_core timer_core_inst (.clock_in(clock_in), .rst_in(rst_in), .address_in(adr),
    .read_in(rdn), .write_in(wrn), .writedata_in(wdat), .readdata_out(rdat),
    .waitrequest_out(wt), .power_reduce_timer_bit_in(pwr), .ext_count_pin_in(pin),
    .wave_out_a_out(wa), .wave_out_b_out(wb), .irq_req_out(irq), .top_out(top),
    .bottom_out(bot), .max_out(mx));
  // ==========================================================
  // Compare, count and report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] x;
    host_model_inst.access(1'b1, a, d, x);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [7:0] e, input string what);
    logic [7:0] x;
    host_model_inst.access(1'b0, a, 8'h00, x);
    chk(x, e, what);
  endtask : rd
  // Bounded wait for a status output, sampled mid-cycle
  task automatic wait_hi(ref logic s);
    for (int i = 0; i < 600 && s !== 1'b1; i++) @(negedge clock_in);
  endtask : wait_hi
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  // Hang guard
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 8000) begin
      n_errors++;
      wrap_up();
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clock_in);
    rst_in <= 1'b0;
    chk({7'h0, bot}, 8'h01, "bottom at reset");
    chk({6'h0, top, mx}, 8'h00, "top max at reset");
    rd(5'h1c, 8'h00, "unmapped read");
    // Stopped counter keeps a written value
    wr(OFS_COUNTER, 8'hfe);
    repeat (20) @(posedge clock_in);
    rd(OFS_COUNTER, 8'hfe, "stopped counter");
    // Normal mode wrap: match A, overflow, masking and clearing
    wr(OFS_CMP_A, 8'hfe); wr(OFS_CMP_B, 8'h80); wr(OFS_MASK, 8'h07);
    wr(OFS_COUNTER, 8'hfc); wr(OFS_CTRL_B, {5'h0, CS_DIV1});
    wait_hi(mx);
    chk({7'h0, top}, 8'h01, "top at max in normal");
    wr(OFS_CTRL_B, {5'h0, CS_STOP});
    rd(OFS_FLAGS, 8'h03, "flags after wrap");
    chk({5'h0, irq}, 8'h03, "requests");
    wr(OFS_MASK, 8'h01);
    @(negedge clock_in);
    chk({5'h0, irq}, 8'h01, "masked requests");
    wr(OFS_FLAGS, 8'h01);
    rd(OFS_FLAGS, 8'h02, "flag cleared");
    // Clear on compare A: top follows compare A
    wr(OFS_CTRL_A, {6'h0, WM_CTC[1:0]}); wr(OFS_CMP_A, 8'h05);
    wr(OFS_COUNTER, 8'h00); wr(OFS_CTRL_B, {5'h0, CS_DIV1});
    wait_hi(top);
    @(negedge clock_in);
    chk({7'h0, bot}, 8'h01, "restart after top");
    wr(OFS_CTRL_B, {5'h0, CS_STOP}); wr(OFS_CTRL_A, 8'h00);
    // External rising edges step the counter by one each
    wr(OFS_COUNTER, 8'h10); wr(OFS_CTRL_B, {5'h0, CS_EXT_RISE});
    host_model_inst.pulses(3);
    wr(OFS_CTRL_B, {5'h0, CS_STOP});
    rd(OFS_COUNTER, 8'h13, "external count");
    // Falling edges only: two pulses add two
    wr(OFS_CTRL_B, {5'h0, CS_EXT_FALL});
    host_model_inst.pulses(2);
    rd(OFS_COUNTER, 8'h15, "external falling count");
    // Fast PWM, top at compare A 6, both outputs clear on match, compare B 3
    wr(OFS_CMP_A, 8'h06);
    wr(OFS_CMP_B, 8'h03);
    wr(OFS_CTRL_A, 8'ha3);
    wr(OFS_COUNTER, 8'h00);
    wr(OFS_CTRL_B, 8'h09);
    wait_hi(top);
    @(negedge clock_in);
    wait_hi(top);
    chk({6'h0, wa, wb}, 8'h02, "fast waves at top");
    wr(OFS_CTRL_B, {5'h0, CS_STOP});
    rd(OFS_FLAGS, 8'h07, "fast flags");
    // Phase correct, top at compare A: six ticks down, six back up
    wr(OFS_CTRL_A, 8'ha1);
    wr(OFS_COUNTER, 8'h00);
    wr(OFS_CTRL_B, 8'h09);
    wait_hi(top);
    repeat (6) @(negedge clock_in);
    chk({7'h0, bot}, 8'h01, "down to bottom");
    repeat (6) @(negedge clock_in);
    chk({7'h0, top}, 8'h01, "back up to top");
    wrap_up();
  end
endmodule : timer_core_test
